// file: logic/iepw_top.sv
/*
  Interrupt enables, low-voltage threshold select, idle and halt entry,
  and wake-up sequencing, on AXI4-Lite.
  Assumes pins are synchronous to clk and the core reports each
  completed instruction with a one-cycle pulse.
*/
// Summary of operation
// [RULE_01] Global enable off blocks every interrupt; intOut, made from the status bits, is not gated by it
// [RULE_02] External pin enable also enables halt wake
// [RULE_03] Halt wake ignores the global enable
// [RULE_04] Low-voltage enable gates detector request
// [RULE_05] Pin-change enable never affects halt wake
// [RULE_06] Threshold code steps 2.05 V by 0.14 V
// [RULE_07] Writing power-down bit enters halt
// [RULE_08] Writing idle bit enters idle
// [RULE_09] Idle ends only on globally enabled interrupt
// [RULE_10] Every enabled source can end idle
// [RULE_11] Idle wake enters service routine at once
// [RULE_12] Wake-capable pin mode enables port wake
// [RULE_13] Halt wake runs one instruction first
// [RULE_14] Post-halt interrupt needs global enable, held level
// [RULE_15] Pin sampled only after warm-up completes
// [RULE_16] Software puts no-ops after power-down write
// [RULE_17] Enabled port pin change sets change flag
// [RULE_18] Writing 7Fh clears low-voltage flag only
// [RULE_19] Mode bit clears itself when mode ends
`timescale 1ns/10ps
`default_nettype none
module iepw_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write channels
  input wire logic [iepw_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [iepw_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // External interrupt pins, active low level
  input wire logic extIrqPin0N,
  input wire logic extIrqPin1N,
  // Port 0 to 3 pin levels, port n at bits 8n+7..8n
  input wire logic [31:0] portPins,
  // Peripheral requests: timer0, timer1, uart, timer2, pwm, adc
  input wire logic [5:0] periphIrq,
  // Analog detector result
  input wire logic lowvoltDetectorOutput,
  // Core handshake
  input wire logic cpuInstrDone,
  output logic irqRequest,
  output logic [9:0] irqSource,
  output logic cpuIdle,
  output logic oscStop,
  output logic oscWarm,
  // Analog detector control
  output logic [3:0] lowvoltSelect,
  output logic [12:0] lowvoltThresholdMv,
  output logic lowvoltDetectorPowerdown,
  // Block interrupt line
  output logic intOut
);
  // Register identifiers after decode
  typedef enum logic [3:0] {
    R_NONE, R_POWER_CONTROL, R_IFLG, R_PIDX, R_IEM, R_IEX, R_LVS,
    R_ISTAT, R_ICLR, R_IEN, R_PM10, R_PM32, R_PM54, R_PM76
  } iepw_reg_type;

  // Whole module state
  typedef struct packed {
    iepw_pkg::iepw_pm_type mode;
    logic [7:0] power_control;
    logic [7:0] ieMain;
    logic [7:0] ieExtra;
    logic lvPowerdown;
    logic [3:0] lvSelect;
    logic lvFlag;
    logic pcFlag;
    logic lvPrev;
    logic [1:0] portIdx;
    logic [3:0][7:0][3:0] pinMode;
    logic [31:0] pinPrev;
    logic [3:0] stat;
    logic [3:0] statEn;
    logic irqReq;
    logic [9:0] irqSrc;
    logic intOut;
    logic [12:0] thresholdMv;
  } iepw_top_type;

  iepw_top_type s, next_s;

  // Bus front end signals
  logic wrFire;
  logic [iepw_pkg::ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [31:0] rdData;
  // Warm-up handshake
  logic warmStart;
  logic warmDone;
  // Port pins whose mode allows wake and interrupt
  logic [31:0] wakeMask;

  // Map a byte address onto a register
  function automatic iepw_reg_type decode(
    input logic [iepw_pkg::ADDR_W-1:0] addr
  );
    iepw_reg_type r;
    r = R_NONE;
    if (addr[1:0] == 2'b00) begin
      case (addr[11:2])
        iepw_pkg::IDX_POWER_CONTROL: r = R_POWER_CONTROL;
        iepw_pkg::IDX_IFLG: r = R_IFLG;
        iepw_pkg::IDX_PIDX: r = R_PIDX;
        iepw_pkg::IDX_IEM: r = R_IEM;
        iepw_pkg::IDX_IEX: r = R_IEX;
        iepw_pkg::IDX_LVS: r = R_LVS;
        iepw_pkg::IDX_ISTAT: r = R_ISTAT;
        iepw_pkg::IDX_ICLR: r = R_ICLR;
        iepw_pkg::IDX_IEN: r = R_IEN;
        iepw_pkg::IDX_PM10: r = R_PM10;
        iepw_pkg::IDX_PM10 + 10'h001: r = R_PM32;
        iepw_pkg::IDX_PM10 + 10'h002: r = R_PM54;
        iepw_pkg::IDX_PM10 + 10'h003: r = R_PM76;
        default: r = R_NONE;
      endcase
    end
    return r;
  endfunction

  // Modes that can interrupt and wake
  function automatic logic wakeCapable(input logic [3:0] m);
    return ~m[1];
  endfunction

  // Pin pair number of a pin mode register
  function automatic logic [1:0] pairOf(input iepw_reg_type r);
    logic [1:0] p;
    case (r)
      R_PM32: p = 2'd1;
      R_PM54: p = 2'd2;
      R_PM76: p = 2'd3;
      default: p = 2'd0;
    endcase
    return p;
  endfunction

  // Per-pin wake capability from its mode field
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_wake
      assign wakeMask[gi] = wakeCapable(s.pinMode[gi / 8][gi % 8]); // [RULE_12]
    end
  endgenerate

  // Bus slave
  iepw_axil_slave u_bus (
    .clk(clk),
    .nrst(nrst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrFire(wrFire),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(decode(wrAddr) != R_NONE),
    .rdData(rdData),
    .rdOk(decode(araddr) != R_NONE)
  );

  // Oscillator warm-up timer
  iepw_warmup u_warm (
    .clk(clk),
    .nrst(nrst),
    .start(warmStart),
    .done(warmDone)
  );

  // Read mux, reserved bits read as zero
  always_comb begin
    iepw_reg_type r;
    logic [1:0] p;
    r = decode(araddr);
    p = pairOf(r);
    rdData = 32'h0000_0000;
    case (r)
      R_POWER_CONTROL: rdData[7:0] = s.power_control;
      R_IFLG: begin
        rdData[iepw_pkg::IFLG_LV] = s.lvFlag;
        rdData[iepw_pkg::IFLG_PC] = s.pcFlag;
      end
      R_PIDX: rdData[1:0] = s.portIdx;
      R_IEM: rdData[7:0] = s.ieMain;
      R_IEX: rdData[7:0] = s.ieExtra;
      R_LVS: begin
        rdData[iepw_pkg::LVS_PD] = s.lvPowerdown;
        rdData[iepw_pkg::LVS_OUT] = lowvoltDetectorOutput;
        rdData[3:0] = s.lvSelect;
      end
      R_ISTAT: rdData[3:0] = s.stat;
      R_IEN: rdData[3:0] = s.statEn;
      R_PM10, R_PM32, R_PM54, R_PM76: begin
        rdData[7:4] = s.pinMode[s.portIdx][{p, 1'b1}];
        rdData[3:0] = s.pinMode[s.portIdx][{p, 1'b0}];
      end
      default: rdData = 32'h0000_0000;
    endcase
  end

  // Next state of registers, flags and mode
  always_comb begin
    iepw_reg_type wr;
    logic [1:0] wp;
    logic wrLow;
    logic sampleOk;
    logic [9:0] src;
    logic anyIrq;
    logic [31:0] pinChange;
    logic haltWake;
    logic lvRise;
    logic pcSet;
    logic [3:0] events;
    next_s = s;
    warmStart = 1'b0;
    wr = decode(wrAddr);
    wp = pairOf(wr);
    wrLow = wrFire && wrStrb[0];
    events = 4'h0;

    // Pins sampled only once clock settled
    sampleOk = (s.mode != iepw_pkg::PM_HALT)
      && (s.mode != iepw_pkg::PM_WARM); // [RULE_15]
    pinChange = (portPins ^ s.pinPrev) & wakeMask;
    next_s.pinPrev = portPins;

    // Halt wake: pin enable alone
    haltWake = (!extIrqPin0N && s.ieMain[iepw_pkg::IE_EX0])
      || (!extIrqPin1N && s.ieMain[iepw_pkg::IE_EX1]) // [RULE_02] [RULE_03]
      || (|pinChange); // [RULE_05] [RULE_12]

    // Detector edge sets the low-voltage flag
    lvRise = lowvoltDetectorOutput && !s.lvPrev && !s.lvPowerdown;
    next_s.lvPrev = lowvoltDetectorOutput;
    // Pin change flag needs its enable
    pcSet = (|pinChange) && s.ieExtra[iepw_pkg::IEX_PC]; // [RULE_17]

    // Register writes, low byte lane only
    if (wrLow) begin
      case (wr)
        R_POWER_CONTROL: next_s.power_control = wrData[7:0] & iepw_pkg::POWER_CONTROL_MASK;
        R_IFLG: begin
          // Zero clears a flag, one leaves it alone
          if (!wrData[iepw_pkg::IFLG_LV]) begin
            next_s.lvFlag = 1'b0; // [RULE_18]
          end
          if (!wrData[iepw_pkg::IFLG_PC]) begin
            next_s.pcFlag = 1'b0;
          end
        end
        R_PIDX: next_s.portIdx = wrData[1:0];
        R_IEM: next_s.ieMain = wrData[7:0] & iepw_pkg::IEM_MASK;
        R_IEX: next_s.ieExtra = wrData[7:0] & iepw_pkg::IEX_MASK;
        R_LVS: begin
          next_s.lvPowerdown = wrData[iepw_pkg::LVS_PD];
          next_s.lvSelect = wrData[3:0];
        end
        R_ICLR: next_s.stat = s.stat & ~wrData[3:0];
        R_IEN: next_s.statEn = wrData[3:0];
        R_PM10, R_PM32, R_PM54, R_PM76: begin
          next_s.pinMode[s.portIdx][{wp, 1'b1}] = wrData[7:4];
          next_s.pinMode[s.portIdx][{wp, 1'b0}] = wrData[3:0];
        end
        default: next_s.portIdx = s.portIdx;
      endcase
    end

    // Hardware sets win over a same-cycle clear
    if (lvRise) begin
      next_s.lvFlag = 1'b1; // [RULE_18]
    end
    if (pcSet) begin
      next_s.pcFlag = 1'b1; // [RULE_17]
    end

    // Enabled requests; pins only when sampled
    src[0] = sampleOk && !extIrqPin0N && s.ieMain[iepw_pkg::IE_EX0];
    src[1] = periphIrq[0] && s.ieMain[iepw_pkg::IE_ET0];
    src[2] = sampleOk && !extIrqPin1N && s.ieMain[iepw_pkg::IE_EX1];
    src[3] = periphIrq[1] && s.ieMain[iepw_pkg::IE_ET1];
    src[4] = periphIrq[2] && s.ieMain[iepw_pkg::IE_ES];
    src[5] = periphIrq[3] && s.ieMain[iepw_pkg::IE_ET2];
    src[6] = periphIrq[4] && s.ieExtra[iepw_pkg::IEX_PWM];
    src[7] = periphIrq[5] && s.ieExtra[iepw_pkg::IEX_ADC];
    src[8] = s.lvFlag && s.ieExtra[iepw_pkg::IEX_LV]; // [RULE_04]
    src[9] = s.pcFlag && s.ieExtra[iepw_pkg::IEX_PC]; // [RULE_05]
    // Global enable gates every source request; halt wake and intOut ignore it
    anyIrq = s.ieMain[iepw_pkg::IE_EA] && (|src); // [RULE_01]

    // Power-mode sequencing
    case (s.mode)
      iepw_pkg::PM_RUN: begin
        if (next_s.power_control[iepw_pkg::POWER_CONTROL_PD]) begin
          next_s.mode = iepw_pkg::PM_HALT; // [RULE_07]
        end else if (next_s.power_control[iepw_pkg::POWER_CONTROL_IDL]) begin
          next_s.mode = iepw_pkg::PM_IDLE; // [RULE_08]
        end
      end
      iepw_pkg::PM_IDLE: begin
        // Any globally enabled source ends idle
        if (anyIrq) begin // [RULE_09] [RULE_10]
          next_s.mode = iepw_pkg::PM_RUN; // [RULE_11]
          next_s.power_control[iepw_pkg::POWER_CONTROL_IDL] = 1'b0; // [RULE_19]
          events[0] = 1'b1;
        end
      end
      iepw_pkg::PM_HALT: begin
        // Oscillator restarts on any wake source
        if (haltWake) begin
          next_s.mode = iepw_pkg::PM_WARM;
          warmStart = 1'b1;
          events[1] = 1'b1;
        end
      end
      iepw_pkg::PM_WARM: begin
        // Core resumes once the clock is settled
        if (warmDone) begin
          next_s.mode = iepw_pkg::PM_RESUME;
          next_s.power_control[iepw_pkg::POWER_CONTROL_PD] = 1'b0; // [RULE_19]
        end
      end
      iepw_pkg::PM_RESUME: begin
        // One instruction runs before any service entry
        if (cpuInstrDone) begin
          next_s.mode = iepw_pkg::PM_RUN; // [RULE_13]
        end
      end
      default: next_s.mode = iepw_pkg::PM_RUN;
    endcase

    // Core request only in run mode
    next_s.irqReq = anyIrq && (next_s.mode == iepw_pkg::PM_RUN); // [RULE_14]
    next_s.irqSrc = src & {10{s.ieMain[iepw_pkg::IE_EA]}}; // [RULE_01]

    // Sticky event status, set wins over clear
    events[2] = lvRise;
    events[3] = pcSet;
    next_s.stat = next_s.stat | events;
    next_s.intOut = |(next_s.stat & next_s.statEn);

    // Detector threshold in millivolts
    next_s.thresholdMv = 13'(iepw_pkg::LV_BASE_MV
      + iepw_pkg::LV_STEP_MV * int'(next_s.lvSelect)); // [RULE_06]
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.mode <= iepw_pkg::PM_RUN;
      s.power_control <= iepw_pkg::RST_BYTE;
      s.ieMain <= iepw_pkg::RST_BYTE;
      s.ieExtra <= iepw_pkg::RST_BYTE;
      s.pinMode <= {32{iepw_pkg::RST_PIN_MODE}};
      s.pinPrev <= 32'hffff_ffff;
      s.thresholdMv <= 13'(iepw_pkg::LV_BASE_MV);
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign irqRequest = s.irqReq;
  assign irqSource = s.irqSrc;
  assign cpuIdle = (s.mode == iepw_pkg::PM_IDLE);
  assign oscStop = (s.mode == iepw_pkg::PM_HALT);
  assign oscWarm = (s.mode == iepw_pkg::PM_WARM);
  assign lowvoltSelect = s.lvSelect; // [RULE_06]
  assign lowvoltThresholdMv = s.thresholdMv;
  assign lowvoltDetectorPowerdown = s.lvPowerdown;
  assign intOut = s.intOut;
endmodule
`default_nettype wire

// file: logic/iepw_pkg.sv
/*
  Shared constants of the interrupt-enable and wake-up block:
  register indexes, fields, reset values, timing and mode states.
  Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package iepw_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
  localparam logic [9:0] IDX_IFLG = 10'h095;
  localparam logic [9:0] IDX_PIDX = 10'h091;
  localparam logic [9:0] IDX_IEM = 10'h0a8;
  localparam logic [9:0] IDX_IEX = 10'h0a9;
  localparam logic [9:0] IDX_LVS = 10'h0bf;
  localparam logic [9:0] IDX_ISTAT = 10'h0c0;
  localparam logic [9:0] IDX_ICLR = 10'h0c1;
  localparam logic [9:0] IDX_IEN = 10'h0c2;
  localparam logic [9:0] IDX_PM10 = 10'h0c4;
  // Power control fields and writable mask
  localparam int POWER_CONTROL_PD = 1;
  localparam int POWER_CONTROL_IDL = 0;
  localparam logic [7:0] POWER_CONTROL_MASK = 8'h8f;
  // Main interrupt enable fields and writable mask
  localparam int IE_EA = 7;
  localparam int IE_ET2 = 5;
  localparam int IE_ES = 4;
  localparam int IE_ET1 = 3;
  localparam int IE_EX1 = 2;
  localparam int IE_ET0 = 1;
  localparam int IE_EX0 = 0;
  localparam logic [7:0] IEM_MASK = 8'hbf;
  // Extra interrupt enable fields and writable mask
  localparam int IEX_PWM = 4;
  localparam int IEX_ADC = 3;
  localparam int IEX_LV = 2;
  localparam int IEX_PC = 1;
  localparam logic [7:0] IEX_MASK = 8'h1e;
  // Low-voltage select and interrupt flag fields
  localparam int LVS_PD = 7;
  localparam int LVS_OUT = 6;
  localparam int IFLG_LV = 7;
  localparam int IFLG_PC = 1;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_PIN_MODE = 4'h1;
  // Threshold ladder in millivolts
  localparam int LV_BASE_MV = 2050;
  localparam int LV_STEP_MV = 140;
  // Warm-up after halt, in whole cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int WARM_TIME_NS = 1600;
  localparam int WARM_CYCLES = (WARM_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  // Power-mode states
  typedef enum logic [2:0] {
    PM_RUN, PM_IDLE, PM_HALT, PM_WARM, PM_RESUME
  } iepw_pm_type;
endpackage

// file: logic/iepw_warmup.sv
/*
  Warm-up timer run after a halt wake.
  Assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/10ps
`default_nettype none
module iepw_warmup (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  output logic done
);
  // Counter state
  typedef struct packed {
    logic [7:0] count;
    logic busy;
    logic done;
  } iepw_warm_type;
  iepw_warm_type s, next_s;
  assign done = s.done;

  // Count down warm-up cycles, pulse done at the end
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.count = 8'(iepw_pkg::WARM_CYCLES - 1);
    end else if (s.busy) begin
      if (s.count == 8'h00) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.count = s.count - 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// file: logic/iepw_axil_slave.sv
/*
  AXI4-Lite slave: write halves in either order, one commit pulse,
  reads from a mux.
  Assumes the register file decodes addresses and reports validity.
*/
`timescale 1ns/10ps
`default_nettype none
module iepw_axil_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Write channels
  input wire logic [iepw_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [iepw_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register file side
  output logic wrFire,
  output logic [iepw_pkg::ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrOk,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);
  // Channel state
  typedef struct packed {
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic [iepw_pkg::ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iepw_axil_type;
  iepw_axil_type s, next_s;

  assign awready = s.awRdy;
  assign wready = s.wRdy;
  assign arready = s.arRdy;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign wrAddr = s.waddr;
  assign wrData = s.wdata;
  assign wrStrb = s.wstrb;

  // Handshakes; commit once both halves of a write are held
  always_comb begin
    next_s = s;
    wrFire = 1'b0;
    if (awvalid && s.awRdy) begin
      next_s.awRdy = 1'b0;
      next_s.waddr = awaddr;
    end
    if (wvalid && s.wRdy) begin
      next_s.wRdy = 1'b0;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (!s.awRdy && !s.wRdy && !s.bvalid) begin
      wrFire = 1'b1;
      next_s.bvalid = 1'b1;
      next_s.bresp = wrOk ? iepw_pkg::RESP_OKAY : iepw_pkg::RESP_SLVERR;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.awRdy = 1'b1;
      next_s.wRdy = 1'b1;
    end
    if (arvalid && s.arRdy) begin
      next_s.arRdy = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rdData;
      next_s.rresp = rdOk ? iepw_pkg::RESP_OKAY : iepw_pkg::RESP_SLVERR;
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arRdy = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.awRdy <= 1'b1;
      s.wRdy <= 1'b1;
      s.arRdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// file: verif/iepw_chk.sv
/* Checker of power modes and bus answers at the top ports.
   Assumes binding onto iepw_top, one clock. */
`timescale 1ns/10ps
`default_nettype none
module iepw_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Core and modes
  input wire logic cpuInstrDone,
  input wire logic irqRequest,
  input wire logic cpuIdle,
  input wire logic oscStop,
  input wire logic oscWarm,
  // Detector control
  input wire logic [3:0] lowvoltSelect,
  input wire logic [12:0] lowvoltThresholdMv
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] warmCnt; // Cycles spent in warm-up
  // Count warm-up cycles, clear outside
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) warmCnt <= 8'h00;
    else warmCnt <= oscWarm ? warmCnt + 8'h01 : 8'h00;
  end
  sequence resume_s; $fell(oscWarm); endsequence
  sequence instr_s; ##[0:60] cpuInstrDone; endsequence
  thr_map_a: assert property (lowvoltThresholdMv ==
    13'(2050 + 140 * lowvoltSelect)) else $error("threshold wrong");
  warm_len_a: assert property ($fell(oscWarm) |->
    warmCnt == 8'(iepw_pkg::WARM_CYCLES + 1)) else $error("warm length");
  halt_warm_a: assert property ($fell(oscStop) |-> oscWarm)
    else $error("no warm-up");
  warm_quiet_a: assert property (oscWarm |-> !irqRequest)
    else $error("warm request");
  resume_a: assert property (resume_s |->
    !irqRequest throughout instr_s) else $error("early request");
  idle_exit_a: assert property ($fell(cpuIdle) |-> irqRequest)
    else $error("idle exit");
  mode_excl_a: assert property (!(cpuIdle && (oscStop || oscWarm)))
    else $error("two modes at once");
  resp_hold_a: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("bresp dropped");
  read_lat_a: assert property ($rose(rvalid) |->
    $past(arvalid && arready) && !arready) else $error("rvalid late");
endmodule
bind iepw_top iepw_chk u_iepw_chk (.clk, .nrst, .arvalid, .arready,
  .rvalid, .bvalid, .bready, .bresp, .cpuInstrDone, .irqRequest, .cpuIdle,
  .oscStop, .oscWarm, .lowvoltSelect, .lowvoltThresholdMv);
`default_nettype wire

// file: verif/iepw_core_model.sv
/* Core model: one instruction every fourth cycle in run mode.
   Assumes the mode outputs of iepw_top. */
`timescale 1ns/10ps
`default_nettype none
module iepw_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Modes
  input wire logic cpuIdle,
  input wire logic oscStop,
  input wire logic oscWarm,
  // Retire pulse
  output logic cpuInstrDone
);
  logic [1:0] phase; // Instruction slot
  // Retires in the fourth-cycle slot; stalls in idle, halt and warm-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
      cpuInstrDone <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      cpuInstrDone <= phase == 2'h3 && !cpuIdle && !oscStop && !oscWarm;
    end
  end
endmodule
`default_nettype wire

// file: verif/iepw_top_tb.sv
/* Testbench: register reads and writes over AXI4-Lite, idle and halt.
   Assumes the core model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module iepw_top_tb;
  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, extIrqPin0N, extIrqPin1N;
  logic lowvoltDetectorOutput, cpuInstrDone, irqRequest, cpuIdle;
  logic oscStop, oscWarm, lowvoltDetectorPowerdown, intOut;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, portPins;
  logic [3:0] wstrb, lowvoltSelect;
  logic [1:0] bresp, rresp, lastResp;
  logic [5:0] periphIrq;
  logic [9:0] irqSource;
  logic [12:0] lowvoltThresholdMv;
  int n_mismatch, checks, cyc;
  localparam logic [11:0] A_POWER_CONTROL = {iepw_pkg::IDX_POWER_CONTROL, 2'b00},
    A_IFLG = {iepw_pkg::IDX_IFLG, 2'b00},
    A_IEM = {iepw_pkg::IDX_IEM, 2'b00},
    A_IEX = {iepw_pkg::IDX_IEX, 2'b00},
    A_LVS = {iepw_pkg::IDX_LVS, 2'b00},
    A_ST = {iepw_pkg::IDX_ISTAT, 2'b00},
    A_CLR = {iepw_pkg::IDX_ICLR, 2'b00},
    A_EN = {iepw_pkg::IDX_IEN, 2'b00},
    A_PM = {iepw_pkg::IDX_PM10, 2'b00};
  // Idle wake: enables and source bit
  logic [7:0] enM [8] = '{8'h81, 8'h82, 8'h88, 8'h90, 8'ha0, 8'h80,
    8'h80, 8'h84};
  logic [7:0] enX [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
    8'h08, 8'h00};
  int srcBit [8] = '{0, 1, 3, 4, 5, 6, 7, 2};
  iepw_top u_iepw_top (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .extIrqPin0N,
    .extIrqPin1N, .portPins, .periphIrq, .lowvoltDetectorOutput,
    .cpuInstrDone, .irqRequest, .irqSource, .cpuIdle, .oscStop, .oscWarm,
    .lowvoltSelect, .lowvoltThresholdMv, .lowvoltDetectorPowerdown,
    .intOut);
  iepw_core_model u_iepw_core_model (.clk, .nrst, .cpuIdle, .oscStop,
    .oscWarm, .cpuInstrDone);
  // Clock of 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: both halves offered, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw = 1'b1, w = 1'b1;
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    lastResp = bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    lastResp = rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chkv(d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_sig(ref logic s, input logic v);
    for (int i = 0; i < 300 && s !== v; i++) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    logic [31:0] d;
    {nrst, awvalid, wvalid, arvalid, lowvoltDetectorOutput} = 5'h00;
    {awaddr, araddr, wdata, portPins, periphIrq} = '0;
    {bready, rready, extIrqPin0N, extIrqPin1N} = 4'hf;
    wstrb = 4'hf;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    tick(1);
    rchk(A_IEM, 32'h0);
    rchk(A_POWER_CONTROL, 32'h0);
    rchk(A_PM, 32'h11);
    rd(12'h400, d);
    chkv(32'(lastResp), 32'(iepw_pkg::RESP_SLVERR));
    for (int c = 0; c < 16; c++) begin
      wr(A_LVS, 8'(c) | 8'h80);
      tick(2);
      chkv(32'(lowvoltThresholdMv), 32'(2050 + 140 * c));
      chkv(32'({lowvoltDetectorPowerdown, lowvoltSelect}),
        32'(c + 16));
    end
    wr(A_LVS, 8'h00);
    wr(A_IEX, 8'h04);
    lowvoltDetectorOutput <= 1'b1;
    tick(3);
    chkv(32'(irqRequest), 32'h0);
    wr(A_IEM, 8'h80);
    tick(3);
    chkv(32'(irqSource[8]), 32'h1);
    wr(A_IEX, 8'h00);
    tick(3);
    chkv(32'(irqSource[8]), 32'h0);
    rchk(A_IFLG, 32'h80);
    wr(A_IFLG, 8'h7f);
    rchk(A_IFLG, 32'h0);
    lowvoltDetectorOutput <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(A_IEX, enX[i]);
      wr(A_IEM, enM[i] & 8'h7f);
      wr(A_POWER_CONTROL, 8'h01);
      tick(2);
      chkv(32'(cpuIdle), 32'h1);
      if (i == 0) extIrqPin0N <= 1'b0;
      else if (i == 7) extIrqPin1N <= 1'b0;
      else periphIrq <= 6'h01 << (i - 1);
      tick(4);
      chkv(32'(cpuIdle), 32'h1);
      wr(A_IEM, enM[i]);
      wait_sig(cpuIdle, 1'b0);
      chkv(32'(irqRequest), 32'h1);
      chkv(32'(irqSource[srcBit[i]]), 32'h1);
      rchk(A_POWER_CONTROL, 32'h0);
      {extIrqPin0N, extIrqPin1N, periphIrq} <= 8'hc0;
      wr(A_IEM, 8'h00);
    end
    // Halt cases: global off, short pulse, held pin, port change
    for (int k = 0; k < 4; k++) begin
      wr(A_IEX, 8'h00);
      wr(A_IEM, k == 3 ? 8'h00 : k == 0 ? 8'h01 : 8'h81);
      wr(A_POWER_CONTROL, 8'h02);
      tick(2);
      chkv(32'(oscStop), 32'h1);
      if (k == 3) portPins <= 32'h1;
      else extIrqPin0N <= 1'b0;
      if (k == 1) begin
        tick(1);
        extIrqPin0N <= 1'b1;
      end
      wait_sig(oscWarm, 1'b1);
      wait_sig(oscWarm, 1'b0);
      tick(12);
      chkv(32'(irqRequest), 32'(k == 2));
      chkv(32'(oscStop), 32'h0);
      extIrqPin0N <= 1'b1;
      rchk(A_POWER_CONTROL, 32'h0);
    end
    rchk(A_ST, 32'h7);
    chkv(32'(intOut), 32'h0);
    wr(A_EN, 8'h02);
    tick(2);
    chkv(32'(intOut), 32'h1);
    wr(A_CLR, 8'h02);
    tick(2);
    chkv(32'(intOut), 32'h0);
    rchk(A_ST, 32'h5);
    wr(A_IEX, 8'h02);
    portPins <= 32'h101;
    tick(3);
    rchk(A_IFLG, 32'h02);
    close_out();
  end
endmodule
`default_nettype wire
